/* File: wd_pkg.sv */
`default_nettype none
package wd_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int WD_DWORD_W = 32;
    localparam int WD_BE_W = 4;
    localparam int WD_CACHE_W = 8;
    localparam int WD_CFG_W = 16;
    localparam int WD_CMD_OUT_W = 10;
    localparam int WD_STAT_OUT_W = 6;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int WD_CMD_RSVD_BIT = 7;
    localparam int WD_CMD_INTX_DIS_BIT = 10;
    localparam int WD_STAT_MDPE_BIT = 8;
    localparam int WD_STAT_STA_BIT = 11;
    localparam int WD_STAT_RTA_BIT = 12;
    localparam int WD_STAT_RMA_BIT = 13;
    localparam int WD_STAT_SSE_BIT = 14;
    localparam int WD_STAT_DPE_BIT = 15;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] WD_DWORD_RST = 32'h0000_0000;
    localparam logic [3:0] WD_BE_IDLE_N = 4'hf;
    localparam logic [7:0] WD_CACHE_RST = 8'h00;
    localparam logic [9:0] WD_CMD_RST = 10'h000;
    localparam logic [5:0] WD_STAT_RST = 6'h00;
    // ****************************************
    // Address capture states
    // ****************************************
    typedef enum logic [1:0] {
        WD_CAP_IDLE = 2'b00,
        WD_CAP_LOW = 2'b01,
        WD_CAP_HIGH = 2'b10
    } wd_cap_state_t;
endpackage
`default_nettype wire

/* File: wd_sub_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface wd_sub_if;
    import wd_pkg::*;
    logic frame_start;
    logic dac;
    logic [WD_DWORD_W-1:0] ad_lo;
    logic [WD_DWORD_W-1:0] ad_hi;
    logic [WD_DWORD_W-1:0] addr_lo_q;
    logic [WD_DWORD_W-1:0] addr_hi_q;
    logic [WD_CACHE_W-1:0] cfg_cache;
    logic [WD_CFG_W-1:0] cfg_command;
    logic [WD_CFG_W-1:0] cfg_status;
    logic [WD_CACHE_W-1:0] cache_q;
    logic [WD_CMD_OUT_W-1:0] command_q;
    logic [WD_STAT_OUT_W-1:0] status_q;
    modport hub (
        output frame_start, dac, ad_lo, ad_hi, cfg_cache, cfg_command, cfg_status,
        input addr_lo_q, addr_hi_q, cache_q, command_q, status_q
    );
    modport addr (
        input frame_start, dac, ad_lo, ad_hi,
        output addr_lo_q, addr_hi_q
    );
    modport cfg (
        input cfg_cache, cfg_command, cfg_status,
        output cache_q, command_q, status_q
    );
endinterface
`default_nettype wire

/* File: wd_addr_capture.sv */
`timescale 1ns/10ps
`default_nettype none
module wd_addr_capture
    import wd_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic resetn, // Async reset, active low
    wd_sub_if.addr sub // Address capture signals
);
    wd_cap_state_t state;
    wd_cap_state_t next_state;
    wire logic load_lo = (state == WD_CAP_LOW);
    wire logic load_hi = (state == WD_CAP_HIGH) && sub.dac;

    always_comb begin
        case (state)
            WD_CAP_IDLE: next_state = WD_CAP_IDLE;
            WD_CAP_LOW: next_state = WD_CAP_HIGH;
            WD_CAP_HIGH: next_state = WD_CAP_IDLE;
            default: next_state = WD_CAP_IDLE;
        endcase
        if (sub.frame_start) begin
            next_state = WD_CAP_LOW;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= WD_CAP_IDLE;
            sub.addr_lo_q <= WD_DWORD_RST;
            sub.addr_hi_q <= WD_DWORD_RST;
        end else begin
            state <= next_state;
            if (load_lo) begin
                sub.addr_lo_q <= sub.ad_lo;
            end
            if (sub.frame_start) begin
                sub.addr_hi_q <= WD_DWORD_RST;
            end else if (load_hi) begin
                sub.addr_hi_q <= sub.ad_hi;
            end
        end
    end

    AST_ADDR_LO_ONE_CLK: assert property (@(posedge ref_clk) disable iff (!resetn)
        sub.frame_start ##1 !sub.frame_start |=> sub.addr_lo_q == $past(sub.ad_lo))
        else $error("lower start address not latched one clock after frame");
    AST_ADDR_HI_DAC: assert property (@(posedge ref_clk) disable iff (!resetn)
        sub.frame_start ##1 !sub.frame_start ##1 (sub.dac && !sub.frame_start)
        |=> sub.addr_hi_q == $past(sub.ad_hi))
        else $error("upper start address not latched two clocks after frame");
    AST_ADDR_HI_SAC: assert property (@(posedge ref_clk) disable iff (!resetn)
        sub.frame_start ##1 !sub.frame_start ##1 !(sub.dac || sub.frame_start)
        |=> sub.addr_hi_q == WD_DWORD_RST)
        else $error("upper start address loaded without dual address cycle");
    AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == WD_CAP_IDLE && !sub.frame_start)
        |=> $stable(sub.addr_lo_q) && $stable(sub.addr_hi_q))
        else $error("start address changed between transactions");
endmodule
`default_nettype wire

/* File: wd_cfg_mirror.sv */
`timescale 1ns/10ps
`default_nettype none
module wd_cfg_mirror
    import wd_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic resetn, // Async reset, active low
    wd_sub_if.cfg sub // Configuration mirror signals
);
    wire logic [WD_CMD_OUT_W-1:0] next_command = {sub.cfg_command[9:8], 1'b0,
        sub.cfg_command[6:0]};
    wire logic [WD_STAT_OUT_W-1:0] next_status = {sub.cfg_status[WD_STAT_DPE_BIT],
        sub.cfg_status[WD_STAT_SSE_BIT], sub.cfg_status[WD_STAT_RMA_BIT],
        sub.cfg_status[WD_STAT_RTA_BIT], sub.cfg_status[WD_STAT_STA_BIT],
        sub.cfg_status[WD_STAT_MDPE_BIT]};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sub.cache_q <= WD_CACHE_RST;
            sub.command_q <= WD_CMD_RST;
            sub.status_q <= WD_STAT_RST;
        end else begin
            sub.cache_q <= sub.cfg_cache;
            sub.command_q <= next_command;
            sub.status_q <= next_status;
        end
    end

    AST_CACHE_FOLLOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 sub.cache_q == $past(sub.cfg_cache))
        else $error("cache line mirror does not follow register");
    AST_CMD_ORDER: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 (sub.command_q[WD_CMD_RSVD_BIT] == 1'b0)
        && (sub.command_q[9] == $past(sub.cfg_command[9]))
        && (sub.command_q[0] == $past(sub.cfg_command[0])))
        else $error("command mirror out of order");
    AST_STAT_MAP: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 (sub.status_q[0] == $past(sub.cfg_status[8]))
        && (sub.status_q[1] == $past(sub.cfg_status[11]))
        && (sub.status_q[5] == $past(sub.cfg_status[15])))
        else $error("status mirror mapping wrong");
    AST_MIRROR_STABLE: assert property (@(posedge ref_clk) disable iff (!resetn)
        $stable(sub.cfg_cache) && $stable(sub.cfg_status) |=> $stable(sub.cache_q)
        && $stable(sub.status_q))
        else $error("mirror changed without register change");
endmodule
`default_nettype wire

/* File: wd_wide_ext.sv */
// Overview of operation
// - Back-end upper input lane carries master address and master-write/target-read data.
// - Upper local data output carries upper DWORD for master reads, target writes.
// - Upper target address latched two clocks after frame, only on dual address.
// - Target start address is upper and lower halves joined into 64 bits.
// - Active-low upper byte enables mark valid upper lanes in 64-bit target transfers.
// - Separate active-low target strobes for lower and upper DWORD.
// - Separate active-low master strobes for lower and upper DWORD.
// - Active-low flag to target side while 64-bit transaction runs.
// - Active-low flag to master side while its own 64-bit transaction runs.
// - Local interrupt request drives PCI interrupt A only when interrupts enabled.
// - Cache line size register mirrored continuously to the local side.
// - Ten command bits output in order, bit 7 reserved.
// - Six status bits from configuration status bits 8, 11 to 15.
// - Strobe marks input data consumed or output data valid that cycle.
`timescale 1ns/10ps
`default_nettype none
module wd_wide_ext
    import wd_pkg::*;
(
    input wire logic ref_clk, // PCI clock, 125 MHz
    input wire logic resetn, // Async reset, active low
    // ****************************************
    // Core side
    // ****************************************
    input wire logic core_frame_start, // First cycle of frame, pulse
    input wire logic core_dac, // Dual address cycle seen
    input wire logic [WD_DWORD_W-1:0] core_tgt_addr_lo, // Lower target address
    input wire logic [WD_DWORD_W-1:0] core_tgt_addr_hi, // Upper target address
    input wire logic [WD_BE_W-1:0] core_tgt_be_hi_n, // Upper PCI byte enables
    input wire logic core_tgt_active, // Target transaction running
    input wire logic core_tgt_wide, // Target transaction is 64-bit
    input wire logic core_tgt_lo_xfer, // Target lower DWORD transfer
    input wire logic core_tgt_hi_xfer, // Target upper DWORD transfer
    input wire logic core_mst_active, // Master transaction running
    input wire logic core_mst_wide, // Master transaction is 64-bit
    input wire logic core_mst_lo_xfer, // Master lower DWORD transfer
    input wire logic core_mst_hi_xfer, // Master upper DWORD transfer
    input wire logic [WD_DWORD_W-1:0] core_data_hi, // Upper data from PCI
    input wire logic [WD_CACHE_W-1:0] cfg_cache, // Cache line size register
    input wire logic [WD_CFG_W-1:0] cfg_command, // Command register
    input wire logic [WD_CFG_W-1:0] cfg_status, // Status register
    output logic [WD_DWORD_W-1:0] core_ad_out_hi, // Upper address/data to PCI
    output logic [WD_BE_W-1:0] core_mst_be_hi_n, // Upper master byte enables to PCI
    output logic pci_int_a_out, // Interrupt A pin level
    output logic pci_int_a_oe, // Interrupt A pin drive enable
    // ****************************************
    // Back-end side
    // ****************************************
    input wire logic [WD_DWORD_W-1:0] local_ad_in_hi, // Upper address/data input
    input wire logic [WD_BE_W-1:0] master_byte_lane_enables_hi_n, // Upper master BEs
    input wire logic local_interrupt_n, // Interrupt request, active low
    output logic [WD_DWORD_W-1:0] local_data_out_hi, // Upper data output
    output logic [2*WD_DWORD_W-1:0] target_start_address, // Full start address
    output logic [WD_BE_W-1:0] target_byte_lane_enables_hi_n, // Upper target BEs
    output logic target_low_dword_strobe_n, // Target lower strobe
    output logic target_high_dword_strobe_n, // Target upper strobe
    output logic target_wide_transfer_flag_n, // Target 64-bit flag
    output logic master_low_dword_strobe_n, // Master lower strobe
    output logic master_high_dword_strobe_n, // Master upper strobe
    output logic master_wide_transfer_flag_n, // Master 64-bit flag
    output logic [WD_CACHE_W-1:0] cache_line_size, // Cache line size mirror
    output logic [WD_CMD_OUT_W-1:0] command_bits, // Command mirror
    output logic [WD_STAT_OUT_W-1:0] status_bits // Status mirror
);
    // ****************************************
    // Submodules
    // ****************************************
    wd_sub_if sub ();

    assign sub.frame_start = core_frame_start;
    assign sub.dac = core_dac;
    assign sub.ad_lo = core_tgt_addr_lo;
    assign sub.ad_hi = core_tgt_addr_hi;
    assign sub.cfg_cache = cfg_cache;
    assign sub.cfg_command = cfg_command;
    assign sub.cfg_status = cfg_status;

    wd_addr_capture u_addr (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sub(sub.addr)
    );

    wd_cfg_mirror u_cfg (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sub(sub.cfg)
    );

    assign target_start_address = {sub.addr_hi_q, sub.addr_lo_q};
    assign cache_line_size = sub.cache_q;
    assign command_bits = sub.command_q;
    assign status_bits = sub.status_q;

    // ****************************************
    // Decode
    // ****************************************
    wire logic tgt_wide_run = core_tgt_active && core_tgt_wide;
    wire logic mst_wide_run = core_mst_active && core_mst_wide;
    wire logic hi_data_load = (tgt_wide_run && core_tgt_hi_xfer)
        || (mst_wide_run && core_mst_hi_xfer);
    wire logic int_enabled = !cfg_command[WD_CMD_INTX_DIS_BIT];
    wire logic next_int_drive = int_enabled && !local_interrupt_n;
    wire logic [WD_BE_W-1:0] next_tgt_be = tgt_wide_run ? core_tgt_be_hi_n : WD_BE_IDLE_N;
    wire logic [WD_BE_W-1:0] next_mst_be = mst_wide_run ? master_byte_lane_enables_hi_n
        : WD_BE_IDLE_N;

    // ****************************************
    // Data lanes
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            core_ad_out_hi <= WD_DWORD_RST;
            local_data_out_hi <= WD_DWORD_RST;
        end else begin
            core_ad_out_hi <= local_ad_in_hi;
            if (hi_data_load) begin
                local_data_out_hi <= core_data_hi;
            end
        end
    end

    // ****************************************
    // Byte enables
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            target_byte_lane_enables_hi_n <= WD_BE_IDLE_N;
            core_mst_be_hi_n <= WD_BE_IDLE_N;
        end else begin
            target_byte_lane_enables_hi_n <= next_tgt_be;
            core_mst_be_hi_n <= next_mst_be;
        end
    end

    // ****************************************
    // Strobes and wide flags
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            target_low_dword_strobe_n <= 1'b1;
            target_high_dword_strobe_n <= 1'b1;
            target_wide_transfer_flag_n <= 1'b1;
            master_low_dword_strobe_n <= 1'b1;
            master_high_dword_strobe_n <= 1'b1;
            master_wide_transfer_flag_n <= 1'b1;
        end else begin
            target_low_dword_strobe_n <= !(core_tgt_active && core_tgt_lo_xfer);
            target_high_dword_strobe_n <= !(tgt_wide_run && core_tgt_hi_xfer);
            target_wide_transfer_flag_n <= !tgt_wide_run;
            master_low_dword_strobe_n <= !(core_mst_active && core_mst_lo_xfer);
            master_high_dword_strobe_n <= !(mst_wide_run && core_mst_hi_xfer);
            master_wide_transfer_flag_n <= !mst_wide_run;
        end
    end

    // ****************************************
    // Interrupt A, open drain
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pci_int_a_out <= 1'b0;
            pci_int_a_oe <= 1'b0;
        end else begin
            pci_int_a_out <= 1'b0;
            pci_int_a_oe <= next_int_drive;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_AD_OUT_FOLLOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 core_ad_out_hi == $past(local_ad_in_hi))
        else $error("upper lane not passed to PCI one clock later");
    AST_HI_DATA_STROBE: assert property (@(posedge ref_clk) disable iff (!resetn)
        !target_high_dword_strobe_n |-> local_data_out_hi == $past(core_data_hi))
        else $error("upper data not valid with target upper strobe");
    AST_HI_DATA_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
        target_high_dword_strobe_n && master_high_dword_strobe_n
        |-> $stable(local_data_out_hi))
        else $error("upper data changed without a strobe");
    AST_TGT_BE_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
        target_wide_transfer_flag_n |-> target_byte_lane_enables_hi_n == WD_BE_IDLE_N)
        else $error("upper target byte enables active outside 64-bit transfer");
    AST_TGT_BE_PASS: assert property (@(posedge ref_clk) disable iff (!resetn)
        tgt_wide_run |=> target_byte_lane_enables_hi_n == $past(core_tgt_be_hi_n))
        else $error("upper target byte enables not passed");
    AST_TGT_HI_STROBE: assert property (@(posedge ref_clk) disable iff (!resetn)
        !target_high_dword_strobe_n |-> !target_wide_transfer_flag_n)
        else $error("target upper strobe outside 64-bit transfer");
    AST_MST_STROBES: assert property (@(posedge ref_clk) disable iff (!resetn)
        (core_mst_active && core_mst_lo_xfer) |=> !master_low_dword_strobe_n)
        else $error("master lower strobe missed");
    AST_TGT_WIDE_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(tgt_wide_run) |=> $fell(target_wide_transfer_flag_n))
        else $error("target 64-bit flag late");
    AST_MST_WIDE_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
        !core_mst_active |=> master_wide_transfer_flag_n && master_high_dword_strobe_n)
        else $error("master 64-bit flag without master transaction");
    AST_INTA_ENABLED: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!local_interrupt_n && !cfg_command[WD_CMD_INTX_DIS_BIT]) |=> pci_int_a_oe)
        else $error("interrupt A not driven on enabled request");
    AST_INTA_MASKED: assert property (@(posedge ref_clk) disable iff (!resetn)
        (local_interrupt_n || cfg_command[WD_CMD_INTX_DIS_BIT]) |=> !pci_int_a_oe)
        else $error("interrupt A driven while disabled or idle");
endmodule
`default_nettype wire

/* File: wd_backend_model.sv */
`timescale 1ns/10ps
`default_nettype none
module wd_backend_model
    import wd_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic load, // Load a new first word
    input wire logic [WD_DWORD_W-1:0] load_val, // First word
    input wire logic [WD_BE_W-1:0] be_req_n, // Upper byte enables to present
    input wire logic irq_req, // Raise interrupt request
    input wire logic xfer_n, // Any upper strobe, active low
    output logic [WD_DWORD_W-1:0] local_ad_in_hi, // Upper address/data
    output logic [WD_BE_W-1:0] master_byte_lane_enables_hi_n, // Upper master BEs
    output logic local_interrupt_n // Interrupt request, active low
);
    // ****************************************
    // Word source, steps on each upper strobe
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            local_ad_in_hi <= WD_DWORD_RST;
        end else if (load) begin
            local_ad_in_hi <= load_val;
        end else if (!xfer_n) begin
            local_ad_in_hi <= local_ad_in_hi + 32'h0000_0001;
        end
    end
    assign master_byte_lane_enables_hi_n = be_req_n;
    assign local_interrupt_n = !irq_req;
endmodule
`default_nettype wire

/* File: pci_core_local_wide_ext_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pci_core_local_wide_ext_tb_top;
    import wd_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic fs = 1'b0, dac = 1'b0, sel = 1'b0, act = 1'b0, wid = 1'b0, lo = 1'b0, hi = 1'b0;
    logic load = 1'b0, irq = 1'b0;
    logic [31:0] alo = 32'h0, ahi = 32'h0, dhi = 32'h0, lval = 32'h0;
    logic [3:0] tbe = 4'hf, mbe = 4'hf;
    logic [7:0] cache = 8'h00;
    logic [15:0] cmd = 16'h0000, stat = 16'h0000;
    logic [31:0] ad_out, ad_in, d_out;
    logic [63:0] tsa;
    logic [3:0] mbe_out, tbe_out, mbe_in;
    logic int_o, int_oe, irq_n, tls, ths, twf, mls, mhs, mwf;
    logic [7:0] cls;
    logic [9:0] cmd_o;
    logic [5:0] st_o;
    int fails = 0;
    int n_checks = 0;
    wire s_lo = sel ? mls : tls;
    wire s_hi = sel ? mhs : ths;
    wire s_wf = sel ? mwf : twf;
    wire [3:0] s_be = sel ? mbe_out : tbe_out;
    always #4 ref_clk = ~ref_clk;
    wd_wide_ext wd_wide_ext_i (.ref_clk(ref_clk), .resetn(resetn), .core_frame_start(fs),
        .core_dac(dac), .core_tgt_addr_lo(alo), .core_tgt_addr_hi(ahi), .core_tgt_be_hi_n(tbe),
        .core_tgt_active(act & !sel), .core_tgt_wide(wid & !sel), .core_tgt_lo_xfer(lo & !sel),
        .core_tgt_hi_xfer(hi & !sel), .core_mst_active(act & sel), .core_mst_wide(wid & sel),
        .core_mst_lo_xfer(lo & sel), .core_mst_hi_xfer(hi & sel), .core_data_hi(dhi),
        .cfg_cache(cache), .cfg_command(cmd), .cfg_status(stat), .core_ad_out_hi(ad_out),
        .core_mst_be_hi_n(mbe_out), .pci_int_a_out(int_o), .pci_int_a_oe(int_oe),
        .local_ad_in_hi(ad_in), .master_byte_lane_enables_hi_n(mbe_in),
        .local_interrupt_n(irq_n), .local_data_out_hi(d_out), .target_start_address(tsa),
        .target_byte_lane_enables_hi_n(tbe_out), .target_low_dword_strobe_n(tls),
        .target_high_dword_strobe_n(ths), .target_wide_transfer_flag_n(twf),
        .master_low_dword_strobe_n(mls), .master_high_dword_strobe_n(mhs),
        .master_wide_transfer_flag_n(mwf), .cache_line_size(cls), .command_bits(cmd_o),
        .status_bits(st_o));
    wd_backend_model wd_backend_model_i (.ref_clk(ref_clk), .resetn(resetn), .load(load),
        .load_val(lval), .be_req_n(mbe), .irq_req(irq), .xfer_n(ths & mhs),
        .local_ad_in_hi(ad_in), .master_byte_lane_enables_hi_n(mbe_in),
        .local_interrupt_n(irq_n));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic edge1();
        @(posedge ref_clk);
        #1;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_addr(input logic d, input logic [31:0] l, input logic [31:0] h);
        @(posedge ref_clk);
        fs <= 1'b1;
        dac <= d;
        alo <= l;
        ahi <= h;
        @(posedge ref_clk);
        fs <= 1'b0;
        repeat (4) edge1();
        chk(tsa, {(d ? h : 32'h0), l});
    endtask
    task automatic t_xfer(input logic m, input logic [31:0] d, input logic [31:0] v);
        @(posedge ref_clk);
        sel <= m;
        load <= 1'b1;
        lval <= v;
        @(posedge ref_clk);
        load <= 1'b0;
        {act, wid, hi} <= 3'b111;
        dhi <= d;
        tbe <= 4'h3;
        mbe <= 4'h3;
        edge1();
        chk(s_hi, 1'b0);
        chk(d_out, d);
        chk(s_wf, 1'b0);
        chk(s_be, 4'h3);
        {hi, lo} <= 2'b01;
        edge1();
        chk(s_hi, 1'b1);
        chk(s_lo, 1'b0);
        {wid, hi, lo} <= 3'b010;
        @(posedge ref_clk);
        {act, hi} <= 2'b00;
        #1;
        chk(s_hi, 1'b1);
        chk(s_wf, 1'b1);
        chk(s_be, 4'hf);
        chk(ad_out, 32'(v + 32'h1));
    endtask
    task automatic t_irq();
        @(posedge ref_clk);
        irq <= 1'b1;
        cmd <= 16'h0000;
        repeat (2) edge1();
        chk({int_oe, int_o}, 2'b10);
        @(posedge ref_clk);
        cmd <= 16'h0400;
        repeat (2) edge1();
        chk(int_oe, 1'b0);
        @(posedge ref_clk);
        irq <= 1'b0;
        cmd <= 16'h0000;
        repeat (2) edge1();
        chk(int_oe, 1'b0);
    endtask
    task automatic t_cfg(input logic [7:0] c, input logic [15:0] k, input logic [15:0] s,
        input logic [9:0] ek, input logic [5:0] es);
        logic [23:0] old;
        old = {cls, cmd_o, st_o};
        @(posedge ref_clk);
        cache <= c;
        cmd <= k;
        stat <= s;
        #1;
        chk({cls, cmd_o, st_o}, old);
        edge1();
        chk({cls, cmd_o, st_o}, {c, ek, es});
    endtask
    initial begin
        #20000;
        fails++;
        results();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        chk({ths, tls, mhs, mls, twf, mwf, tbe_out, int_oe}, {6'h3f, 4'hf, 1'b0});
        chk(tsa, 64'h0);
        t_addr(1'b1, 32'h1234_5670, 32'h89ab_cdef);
        t_addr(1'b0, 32'h0000_0ff0, 32'h5555_aaaa);
        t_xfer(1'b0, 32'hdead_beef, 32'h0000_0010);
        t_xfer(1'b1, 32'hcafe_f00d, 32'hffff_ffff);
        t_irq();
        t_cfg(8'ha5, 16'hffff, 16'hffff, 10'h37f, 6'h3f);
        t_cfg(8'h10, 16'h02aa, 16'h4900, 10'h22a, 6'h13);
        t_cfg(8'h10, 16'h02aa, 16'h4900, 10'h22a, 6'h13);
        results();
    end
endmodule
`default_nettype wire
